// ===== src/ftal_pkg.sv
// package: constants for the failure transfer and alarm block
package ftal_pkg;
   // alarm function selector codes (4 bits, other codes are ordinary alarms)
   localparam logic [3:0] FN_NONE        = 4'h0;
   localparam logic [3:0] FN_LOOP_BREAK  = 4'h1;
   localparam logic [3:0] FN_SENSOR_BRK  = 4'h2;
   localparam logic [3:0] FN_DWELL_TIMER = 4'h3;
   // alarm mode selector codes
   localparam logic [1:0] MD_NORMAL      = 2'h0;
   localparam logic [1:0] MD_LATCH       = 2'h1;
   localparam logic [1:0] MD_HOLD        = 2'h2;
   localparam logic [1:0] MD_LATCH_HOLD  = 2'h3;
   // process value source selector codes
   localparam logic [2:0] PV_IN1         = 3'h0;
   localparam logic [2:0] PV_IN2         = 3'h1;
   localparam logic [2:0] PV_DIFF12      = 3'h2;
   localparam logic [2:0] PV_DIFF21      = 3'h3;
   // set point source selector codes
   localparam logic [1:0] SPS_LOCAL      = 2'h0;
   localparam logic [1:0] SPS_IN1        = 2'h1;
   localparam logic [1:0] SPS_IN2        = 2'h2;
   // input range selector codes
   localparam logic [1:0] RNG_OTHER      = 2'h0;
   localparam logic [1:0] RNG_CURRENT    = 2'h1;
   localparam logic [1:0] RNG_VOLTAGE    = 2'h2;
   // input thresholds, microamps and millivolts
   localparam logic [15:0] MIN_CURRENT_UA = 16'h03E8;
   localparam logic [15:0] MIN_VOLTAGE_MV = 16'h00FA;
   // output 2 role selector
   localparam logic [1:0] ROLE_COOLING   = 2'h1;
   localparam logic [1:0] ROLE_ALARM2    = 2'h2;
   // output 1 action selector
   localparam logic       ACT_REVERSE    = 1'b0;
   // percent scale in 0.1 % units; bumpless code above the top of scale
   localparam logic [10:0] PCT_FULL      = 11'h3E8;
   localparam logic [10:0] BUMPLESS_CODE = 11'h7FF;
   // timing: 100 MHz clock
   localparam int CLK_HZ        = 100_000_000;
   localparam int POWER_UP_MS   = 2500;
   localparam longint POWER_UP_CYC = longint'(CLK_HZ) / 1000 * POWER_UP_MS;
   localparam int LB_MAX_S      = 120;
   // one tick per second drives the loop break window counter
   localparam longint SEC_CYC   = longint'(CLK_HZ);
endpackage

// ===== src/ftal_alarm.sv
// one alarm channel: function, mode, failure transfer and loop break window
`timescale 1ns/1ns
`default_nettype none
module ftal_alarm (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        enable,
   input  wire logic [3:0]  func_sel,
   input  wire logic [1:0]  mode_sel,
   input  wire logic        failure_state,
   input  wire logic        cond_in,
   input  wire logic        pv_at_sp,
   input  wire logic        failure_mode,
   input  wire logic        latch_clear,
   input  wire logic        sec_tick,
   input  wire logic        cv1_at_max,
   input  wire logic        cv1_at_min,
   input  wire logic        pv_rose,
   input  wire logic        pv_fell,
   input  wire logic [7:0]  window_s,
   output logic             alarm_out,
   output logic             params_hidden,
   output logic             loop_break
);
   logic       is_loopbrk;
   logic       is_sb;
   logic       is_tm;
   logic       hold_req;
   logic       armed_r;
   logic       latched_r;
   logic [7:0] win_cnt_r;
   logic       raw_cond;
   logic       live;

   assign is_loopbrk = enable && func_sel == ftal_pkg::FN_LOOP_BREAK;
   assign is_sb = enable && func_sel == ftal_pkg::FN_SENSOR_BRK;
   assign is_tm = enable && func_sel == ftal_pkg::FN_DWELL_TIMER;
   // dwell time, set point, deviation and hysteresis hidden
   assign params_hidden = is_loopbrk || is_sb;
   // holding for every function except the two break alarms
   assign hold_req = (mode_sel == ftal_pkg::MD_HOLD || mode_sel == ftal_pkg::MD_LATCH_HOLD)
                     && !is_loopbrk && !is_sb;

   // ****************************************************************
   // loop break window
   // ****************************************************************
   // counts seconds only while cv1 stays pinned without pv response
   always_ff @(posedge clock) begin
      if (rst) begin
         win_cnt_r <= 8'h00;
      end else if (!is_loopbrk || !(cv1_at_max || cv1_at_min)
                   || (cv1_at_max && pv_rose) || (cv1_at_min && pv_fell)) begin
         win_cnt_r <= 8'h00;
      end else if (sec_tick && win_cnt_r < window_s) begin
         win_cnt_r <= win_cnt_r + 8'h01;
      end
   end
   assign loop_break = is_loopbrk && window_s != 8'h00 && win_cnt_r >= window_s;

   // condition source per function
   assign raw_cond = is_loopbrk ? loop_break : (is_sb ? failure_mode : cond_in);

   // hold arms once pv reaches set point
   always_ff @(posedge clock) begin
      if (rst) begin
         armed_r <= 1'b0;
      end else if (pv_at_sp) begin
         armed_r <= 1'b1;
      end
   end
   assign live = raw_cond && (!hold_req || armed_r);

   // latching keeps output until event clears it; set beats clear
   always_ff @(posedge clock) begin
      if (rst) begin
         latched_r <= 1'b0;
      end else if (live && (mode_sel == ftal_pkg::MD_LATCH
                            || mode_sel == ftal_pkg::MD_LATCH_HOLD)) begin
         latched_r <= 1'b1;
      end else if (latch_clear) begin
         latched_r <= 1'b0;
      end
   end

   // ****************************************************************
   // output with failure transfer
   // ****************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         alarm_out <= 1'b0;
      end else if (!enable) begin
         alarm_out <= 1'b0;
      end else if (failure_mode && !is_tm) begin
         alarm_out <= (is_loopbrk || is_sb) ? 1'b1 : failure_state;
      end else begin
         alarm_out <= live || latched_r;
      end
   end

   property p_break_on;
      @(posedge clock) disable iff (rst)
      (failure_mode && (is_loopbrk || is_sb)) |=> alarm_out;
   endproperty
   a_break_on: assert property (p_break_on) else $error("break alarm not forced on");

   property p_preset;
      @(posedge clock) disable iff (rst)
      (failure_mode && enable && !is_tm && !is_loopbrk && !is_sb)
      |=> alarm_out == $past(failure_state);
   endproperty
   a_preset: assert property (p_preset) else $error("alarm failure preset ignored");

   property p_normal;
      @(posedge clock) disable iff (rst)
      (enable && !failure_mode && mode_sel == ftal_pkg::MD_NORMAL && !latched_r && !hold_req)
      |=> alarm_out == $past(raw_cond);
   endproperty
   a_normal: assert property (p_normal) else $error("normal alarm mismatch");

   property p_latch;
      @(posedge clock) disable iff (rst)
      (latched_r && !latch_clear) |=> latched_r;
   endproperty
   a_latch: assert property (p_latch) else $error("latch dropped");

   property p_win_restart;
      @(posedge clock) disable iff (rst)
      (is_loopbrk && !cv1_at_max && !cv1_at_min) |=> win_cnt_r == 8'h00;
   endproperty
   a_win_restart: assert property (p_win_restart) else $error("window not restarted");
endmodule
`default_nettype wire

// ===== src/ftal_top.sv
// top: failure detection, output failure transfer and two alarm channels
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - alarm 1 loop break by function select
// - alarm 2 loop break needs output-2 alarm role
// - loop break hides alarm adjust parameters
// - loop break never applies holding
// - window twice integral time, max 120s
// - pinned cv1 without pv response trips alarm
// - either alarm may be sensor break
// - sensor break alarm follows failure mode
// - sensor break hides alarm adjust parameters
// - sensor break never applies holding
// - input-1 break error when input 1 used
// - input-2 break error when input 2 used
// - failure mode from breaks or converter fault
// - transfer at power-up, failure, manual, calibration
// - output 1 bumpless uses averaged cv1
// - output 1 preset percentage on transfer
// - on-off output 1 off reverse, on direct
// - cooling output 2 bumpless uses averaged cv2
// - cooling output 2 preset percentage
// - alarms take preset state on failure
// - break alarms forced on in failure
// - dwell timer alarm keeps normal behaviour
// - normal mode follows alarm condition
// - latch holds until event input
module ftal_top #(
   parameter longint POWER_UP_CYCLES = ftal_pkg::POWER_UP_CYC,
   parameter longint SECOND_CYCLES   = ftal_pkg::SEC_CYC
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        in1_open,
   input  wire logic [1:0]  in1_range,
   input  wire logic [15:0] in1_level,
   input  wire logic        in2_open,
   input  wire logic [1:0]  in2_range,
   input  wire logic [15:0] in2_level,
   input  wire logic        adc_failed,
   input  wire logic [2:0]  process_value_select,
   input  wire logic [1:0]  setpoint_source_select,
   input  wire logic        manual_mode,
   input  wire logic        calibration_mode,
   input  wire logic [10:0] control_variable_one,
   input  wire logic [10:0] control_variable_two,
   input  wire logic [10:0] cv1_average,
   input  wire logic [10:0] cv2_average,
   input  wire logic        cv1_on,
   input  wire logic [15:0] first_proportional_band,
   input  wire logic        output1_action_select,
   input  wire logic [10:0] output1_failure_setting,
   input  wire logic [10:0] output2_failure_setting,
   input  wire logic [1:0]  output2_role_select,
   input  wire logic [7:0]  first_integral_time,
   input  wire logic        pv_rose,
   input  wire logic        pv_fell,
   input  wire logic        pv_at_sp,
   input  wire logic        latch_clear_event,
   input  wire logic [3:0]  alarm1_function_select,
   input  wire logic [3:0]  alarm2_function_select,
   input  wire logic [1:0]  alarm1_mode_select,
   input  wire logic [1:0]  alarm2_mode_select,
   input  wire logic        alarm1_failure_state,
   input  wire logic        alarm2_failure_state,
   input  wire logic        alarm1_condition,
   input  wire logic        alarm2_condition,
   output logic             input1_break_error,
   output logic             input2_break_error,
   output logic             converter_fault_error,
   output logic             failure_mode,
   output logic             transfer_active,
   output logic [10:0]      output1_level,
   output logic             output1_switch,
   output logic [10:0]      output2_level,
   output logic             alarm1_out,
   output logic             alarm2_out,
   output logic             alarm1_params_hidden,
   output logic             alarm2_params_hidden,
   output logic             loop_break_active
);
   logic [31:0] pwr_cnt_r;
   logic        pwr_up;
   logic [31:0] sec_cnt_r;
   logic        sec_tick;
   logic [7:0]  window_s;
   logic        cv1_max;
   logic        cv1_min;
   logic        in1_used;
   logic        in2_used;
   logic        sb1;
   logic        sb2;
   logic        fail_now;
   logic        xfer;
   logic        on_off;
   logic        cooling;
   logic        loopbrk1;
   logic        loopbrk2;

   // break test: open wire, or live-zero underflow in current/voltage range
   function automatic logic brk(input logic open, input logic [1:0] rng,
                                input logic [15:0] lvl);
      brk = open
            || (rng == ftal_pkg::RNG_CURRENT && lvl < ftal_pkg::MIN_CURRENT_UA)
            || (rng == ftal_pkg::RNG_VOLTAGE && lvl < ftal_pkg::MIN_VOLTAGE_MV);
   endfunction

   // ****************************************************************
   // failure detection
   // ****************************************************************
   assign in1_used = process_value_select != ftal_pkg::PV_IN2
                     || setpoint_source_select == ftal_pkg::SPS_IN1;
   assign in2_used = process_value_select == ftal_pkg::PV_IN2
                     || process_value_select == ftal_pkg::PV_DIFF12
                     || process_value_select == ftal_pkg::PV_DIFF21
                     || setpoint_source_select == ftal_pkg::SPS_IN2;
   assign sb1 = in1_used && brk(in1_open, in1_range, in1_level);
   assign sb2 = in2_used && brk(in2_open, in2_range, in2_level);
   assign fail_now = sb1 || sb2 || adc_failed;

   // registered error flags; failure mode follows them
   always_ff @(posedge clock) begin
      if (rst) begin
         input1_break_error    <= 1'b0;
         input2_break_error    <= 1'b0;
         converter_fault_error <= 1'b0;
         failure_mode          <= 1'b0;
      end else begin
         input1_break_error    <= sb1;
         input2_break_error    <= sb2;
         converter_fault_error <= adc_failed;
         failure_mode          <= fail_now;
      end
   end

   // ****************************************************************
   // power-up window and second tick
   // ****************************************************************
   // reset stands in for power-on; counter saturates at the window end
   always_ff @(posedge clock) begin
      if (rst) begin
         pwr_cnt_r <= 32'h00000000;
      end else if (pwr_up) begin
         pwr_cnt_r <= pwr_cnt_r + 32'h00000001;
      end
   end
   assign pwr_up = pwr_cnt_r < 32'(POWER_UP_CYCLES);

   always_ff @(posedge clock) begin
      if (rst || sec_tick) begin
         sec_cnt_r <= 32'h00000000;
      end else begin
         sec_cnt_r <= sec_cnt_r + 32'h00000001;
      end
   end
   assign sec_tick = sec_cnt_r == 32'(SECOND_CYCLES - 1);

   // window is twice the integral time, clipped at the maximum
   assign window_s = ({1'b0, first_integral_time} * 9'h002 > 9'(ftal_pkg::LB_MAX_S))
                     ? 8'(ftal_pkg::LB_MAX_S)
                     : 8'({1'b0, first_integral_time} * 9'h002);
   assign cv1_max = control_variable_one >= ftal_pkg::PCT_FULL;
   assign cv1_min = control_variable_one == 11'h000;

   // ****************************************************************
   // output failure transfer
   // ****************************************************************
   assign xfer    = pwr_up || failure_mode || manual_mode || calibration_mode;
   assign on_off  = first_proportional_band == 16'h0000;
   assign cooling = output2_role_select == ftal_pkg::ROLE_COOLING;

   // output 1: bumpless, preset percent, or on-off forced state
   always_ff @(posedge clock) begin
      if (rst) begin
         output1_level  <= 11'h000;
         output1_switch <= 1'b0;
      end else if (!xfer) begin
         output1_level  <= control_variable_one;
         output1_switch <= cv1_on;
      end else if (on_off) begin
         output1_level  <= 11'h000;
         output1_switch <= output1_action_select != ftal_pkg::ACT_REVERSE;
      end else if (output1_failure_setting == ftal_pkg::BUMPLESS_CODE) begin
         output1_level  <= cv1_average;
         output1_switch <= 1'b0;
      end else begin
         // out-of-scale presets clamp to full rather than drive garbage
         output1_level  <= (output1_failure_setting > ftal_pkg::PCT_FULL)
                           ? ftal_pkg::PCT_FULL : output1_failure_setting;
         output1_switch <= 1'b0;
      end
   end

   // output 2 only transfers in cooling role; bumpless keyed on its own setting
   always_ff @(posedge clock) begin
      if (rst) begin
         output2_level <= 11'h000;
      end else if (!cooling) begin
         output2_level <= 11'h000;
      end else if (!xfer) begin
         output2_level <= control_variable_two;
      end else if (output2_failure_setting == ftal_pkg::BUMPLESS_CODE) begin
         output2_level <= cv2_average;
      end else begin
         output2_level <= (output2_failure_setting > ftal_pkg::PCT_FULL)
                          ? ftal_pkg::PCT_FULL : output2_failure_setting;
      end
   end
   assign transfer_active = xfer;

   // ****************************************************************
   // alarm channels
   // ****************************************************************
   ftal_alarm u_alarm1 (
      .clock         (clock),
      .rst           (rst),
      .enable        (1'b1),
      .func_sel      (alarm1_function_select),
      .mode_sel      (alarm1_mode_select),
      .failure_state (alarm1_failure_state),
      .cond_in       (alarm1_condition),
      .pv_at_sp      (pv_at_sp),
      .failure_mode  (failure_mode),
      .latch_clear   (latch_clear_event),
      .sec_tick      (sec_tick),
      .cv1_at_max    (cv1_max),
      .cv1_at_min    (cv1_min),
      .pv_rose       (pv_rose),
      .pv_fell       (pv_fell),
      .window_s      (window_s),
      .alarm_out     (alarm1_out),
      .params_hidden (alarm1_params_hidden),
      .loop_break    (loopbrk1)
   );

   // alarm 2 exists only when output 2 is in its alarm role
   ftal_alarm u_alarm2 (
      .clock         (clock),
      .rst           (rst),
      .enable        (output2_role_select == ftal_pkg::ROLE_ALARM2),
      .func_sel      (alarm2_function_select),
      .mode_sel      (alarm2_mode_select),
      .failure_state (alarm2_failure_state),
      .cond_in       (alarm2_condition),
      .pv_at_sp      (pv_at_sp),
      .failure_mode  (failure_mode),
      .latch_clear   (latch_clear_event),
      .sec_tick      (sec_tick),
      .cv1_at_max    (cv1_max),
      .cv1_at_min    (cv1_min),
      .pv_rose       (pv_rose),
      .pv_fell       (pv_fell),
      .window_s      (window_s),
      .alarm_out     (alarm2_out),
      .params_hidden (alarm2_params_hidden),
      .loop_break    (loopbrk2)
   );
   assign loop_break_active = loopbrk1 || loopbrk2;

   property p_fail_entry;
      @(posedge clock) disable iff (rst)
      adc_failed |=> failure_mode;
   endproperty
   a_fail_entry: assert property (p_fail_entry) else $error("converter fault missed");

   property p_sb1;
      @(posedge clock) disable iff (rst)
      (process_value_select == ftal_pkg::PV_IN1 && (in1_open
       || (in1_range == ftal_pkg::RNG_CURRENT && in1_level < ftal_pkg::MIN_CURRENT_UA)))
      |=> input1_break_error;
   endproperty
   a_sb1: assert property (p_sb1) else $error("input 1 break missed");

   property p_sb2;
      @(posedge clock) disable iff (rst)
      (process_value_select == ftal_pkg::PV_IN2 && (in2_open
       || (in2_range == ftal_pkg::RNG_VOLTAGE && in2_level < ftal_pkg::MIN_VOLTAGE_MV)))
      |=> input2_break_error;
   endproperty
   a_sb2: assert property (p_sb2) else $error("input 2 break missed");

   property p_onoff;
      @(posedge clock) disable iff (rst)
      (xfer && on_off) |=> output1_switch == ($past(output1_action_select)
                                                     != ftal_pkg::ACT_REVERSE);
   endproperty
   a_onoff: assert property (p_onoff) else $error("on-off transfer state wrong");

   property p_bumpless1;
      @(posedge clock) disable iff (rst)
      (xfer && !on_off && output1_failure_setting == ftal_pkg::BUMPLESS_CODE)
      |=> output1_level == $past(cv1_average);
   endproperty
   a_bumpless1: assert property (p_bumpless1) else $error("output 1 not bumpless");

   property p_preset2;
      @(posedge clock) disable iff (rst)
      (xfer && cooling && output2_failure_setting <= ftal_pkg::PCT_FULL)
      |=> output2_level == $past(output2_failure_setting);
   endproperty
   a_preset2: assert property (p_preset2) else $error("output 2 preset wrong");

   property p_powerup;
      @(posedge clock) $fell(rst) |-> transfer_active [*4];
   endproperty
   a_powerup: assert property (p_powerup) else $error("no transfer after power-up");
endmodule
`default_nettype wire

// ===== sim/ftal_plant.sv
// sensor and process model at the far side of the failure transfer block
`timescale 1ns/1ns
`default_nettype none
// ************************************
// sensor and process model
// ************************************
module ftal_plant (
   input  wire logic        clock,
   input  wire logic [15:0] set1,
   input  wire logic [15:0] set2,
   input  wire logic        respond,
   input  wire logic [10:0] drive,
   output logic             in1_open,
   output logic [1:0]       in1_range,
   output logic [15:0]      in1_level,
   output logic             in2_open,
   output logic [1:0]       in2_range,
   output logic [15:0]      in2_level,
   output var logic         pv_rose
);
   // an all-ones setting stands for a cut wire
   assign in1_open  = (set1 == 16'hFFFF);
   assign in2_open  = (set2 == 16'hFFFF);
   assign in1_range = ftal_pkg::RNG_CURRENT;
   assign in2_range = ftal_pkg::RNG_VOLTAGE;
   // a cut wire reads zero, never the last good reading
   assign in1_level = in1_open ? 16'h0000 : set1;
   assign in2_level = in2_open ? 16'h0000 : set2;
   // process warms one cycle after heat, only while the loop is closed
   always_ff @(posedge clock) begin
      pv_rose <= respond && (drive != 11'h000);
   end
endmodule
`default_nettype wire

// ===== sim/ftal_top_tb_top.sv
// testbench for the failure transfer and alarm block
`timescale 1ns/1ns
`default_nettype none
// ************************************
// bench top
// ************************************
module ftal_top_tb_top;
   logic clock, rst, adc_failed, manual_mode, calibration_mode, cv1_on, output1_action_select;
   logic pv_fell, pv_at_sp, latch_clear_event, alarm1_failure_state, alarm2_failure_state;
   logic alarm1_condition, alarm2_condition, respond, pv_rose, in1_open, in2_open;
   logic [1:0]  in1_range, in2_range, setpoint_source_select, output2_role_select;
   logic [1:0]  alarm1_mode_select, alarm2_mode_select;
   logic [2:0]  process_value_select;
   logic [3:0]  alarm1_function_select, alarm2_function_select;
   logic [7:0]  first_integral_time;
   logic [10:0] control_variable_one, control_variable_two, cv1_average, cv2_average;
   logic [10:0] output1_failure_setting, output2_failure_setting, output1_level, output2_level;
   logic [15:0] in1_level, in2_level, first_proportional_band, set1, set2;
   logic input1_break_error, input2_break_error, converter_fault_error, failure_mode;
   logic transfer_active, output1_switch, alarm1_out, alarm2_out, loop_break_active;
   logic alarm1_params_hidden, alarm2_params_hidden;
   int   miscompares, comparisons, cycles;

   // short power-up window and second so the run stays brief
   ftal_top #(.POWER_UP_CYCLES(20), .SECOND_CYCLES(4)) u_ftal_top (
      .clock, .rst, .in1_open, .in1_range, .in1_level, .in2_open, .in2_range, .in2_level,
      .adc_failed, .process_value_select, .setpoint_source_select, .manual_mode,
      .calibration_mode, .control_variable_one, .control_variable_two, .cv1_average,
      .cv2_average, .cv1_on, .first_proportional_band, .output1_action_select,
      .output1_failure_setting, .output2_failure_setting, .output2_role_select,
      .first_integral_time, .pv_rose, .pv_fell, .pv_at_sp, .latch_clear_event,
      .alarm1_function_select, .alarm2_function_select, .alarm1_mode_select,
      .alarm2_mode_select, .alarm1_failure_state, .alarm2_failure_state, .alarm1_condition,
      .alarm2_condition, .input1_break_error, .input2_break_error, .converter_fault_error,
      .failure_mode, .transfer_active, .output1_level, .output1_switch, .output2_level,
      .alarm1_out, .alarm2_out, .alarm1_params_hidden, .alarm2_params_hidden,
      .loop_break_active);
   ftal_plant u_ftal_plant (.clock, .set1, .set2, .respond, .drive(output1_level),
      .in1_open, .in1_range, .in1_level, .in2_open, .in2_range, .in2_level, .pv_rose);

   always #5 clock = ~clock;
   // hang guard: the sequence needs under 200 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         results();
      end
   end

   // outputs are looked at mid-cycle, after the edge's updates have landed
   task automatic wt(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic cb(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic cl(input logic [10:0] got, input logic [10:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: level %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ************************************
   // test sequence
   // ************************************
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      cycles = 0;
      miscompares = 0;
      comparisons = 0;
      adc_failed = 1'b0;
      manual_mode = 1'b0;
      calibration_mode = 1'b0;
      cv1_on = 1'b0;
      output1_action_select = ftal_pkg::ACT_REVERSE;
      pv_fell = 1'b0;
      pv_at_sp = 1'b0;
      latch_clear_event = 1'b0;
      alarm1_failure_state = 1'b0;
      alarm2_failure_state = 1'b0;
      alarm1_condition = 1'b0;
      alarm2_condition = 1'b0;
      respond = 1'b0;
      setpoint_source_select = ftal_pkg::SPS_LOCAL;
      output2_role_select = ftal_pkg::ROLE_COOLING;
      alarm1_mode_select = ftal_pkg::MD_NORMAL;
      alarm2_mode_select = ftal_pkg::MD_NORMAL;
      process_value_select = ftal_pkg::PV_IN1;
      first_integral_time = 8'h00;
      alarm1_function_select = ftal_pkg::FN_SENSOR_BRK;
      alarm2_function_select = ftal_pkg::FN_NONE;
      control_variable_one = 11'h0C8;
      control_variable_two = 11'h064;
      cv1_average = 11'h12C;
      cv2_average = 11'h190;
      first_proportional_band = 16'h0064;
      output1_failure_setting = 11'h1F4;
      output2_failure_setting = ftal_pkg::BUMPLESS_CODE;
      set1 = 16'h1388;
      set2 = 16'h0BB8;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      wt(2);
      cb(transfer_active, 1'b1);
      cl(output1_level, 11'h1F4);
      wt(25);
      cb(transfer_active, 1'b0);
      $display("power-up test done");
      @(posedge clock);
      manual_mode <= 1'b1;
      wt(3);
      cl(output2_level, 11'h190);
      @(posedge clock);
      output1_failure_setting <= ftal_pkg::BUMPLESS_CODE;
      output2_failure_setting <= 11'h0FA;
      wt(3);
      cl(output1_level, 11'h12C);
      cl(output2_level, 11'h0FA);
      @(posedge clock);
      manual_mode <= 1'b0;
      calibration_mode <= 1'b1;
      first_proportional_band <= 16'h0000;
      wt(3);
      cb(output1_switch, 1'b0);
      @(posedge clock);
      output1_action_select <= 1'b1;
      wt(3);
      cb(output1_switch, 1'b1);
      $display("output transfer test done");
      @(posedge clock);
      calibration_mode <= 1'b0;
      set1 <= 16'h03E8;
      wt(3);
      cb(input1_break_error, 1'b0);
      @(posedge clock);
      set1 <= 16'h03E7;
      wt(3);
      cb(input1_break_error, 1'b1);
      cb(failure_mode, 1'b1);
      cb(alarm1_out, 1'b1);
      cb(alarm2_out, 1'b0);
      @(posedge clock);
      set1 <= 16'h1388;
      process_value_select <= ftal_pkg::PV_IN2;
      set2 <= 16'h00F9;
      wt(3);
      cb(input2_break_error, 1'b1);
      @(posedge clock);
      set2 <= 16'h0BB8;
      output2_role_select <= ftal_pkg::ROLE_ALARM2;
      alarm1_function_select <= ftal_pkg::FN_DWELL_TIMER;
      alarm2_failure_state <= 1'b1;
      adc_failed <= 1'b1;
      wt(3);
      cb(converter_fault_error, 1'b1);
      cb(alarm2_out, 1'b1);
      cb(alarm1_out, 1'b0);
      @(posedge clock);
      adc_failed <= 1'b0;
      alarm2_mode_select <= ftal_pkg::MD_LATCH;
      alarm2_condition <= 1'b1;
      wt(3);
      cb(alarm2_out, 1'b1);
      @(posedge clock);
      alarm2_condition <= 1'b0;
      wt(3);
      cb(alarm2_out, 1'b1);
      @(posedge clock);
      latch_clear_event <= 1'b1;
      wt(3);
      cb(alarm2_out, 1'b0);
      $display("failure test done");
      @(posedge clock);
      latch_clear_event <= 1'b0;
      alarm1_function_select <= ftal_pkg::FN_LOOP_BREAK;
      // holding mode with pv never at set point: a held alarm would stay off
      alarm1_mode_select <= ftal_pkg::MD_HOLD;
      alarm2_function_select <= ftal_pkg::FN_SENSOR_BRK;
      first_integral_time <= 8'h02;
      control_variable_one <= 11'h3E8;
      wt(1);
      cb(alarm1_params_hidden, 1'b1);
      cb(alarm2_params_hidden, 1'b1);
      wt(10);
      cb(loop_break_active, 1'b0);
      wt(14);
      cb(loop_break_active, 1'b1);
      cb(alarm1_out, 1'b1);
      @(posedge clock);
      control_variable_one <= 11'h1F4;
      wt(3);
      cb(loop_break_active, 1'b0);
      $display("loop break test done");
      results();
   end
endmodule
`default_nettype wire
